/* logic/hss_defines.svh */
`ifndef HSS_DEFINES_SVH
`define HSS_DEFINES_SVH

// register indices; byte address is four times the index
`define HSS_IDX_SLOT_CTRL 10'h058
`define HSS_IDX_SLOT_STATUS 10'h05A
`define HSS_IDX_DEV_CAP2 10'h064
`define HSS_IDX_DEV_CTRL2 10'h068
`define HSS_IDX_DEV_STAT2 10'h06A
`define HSS_IDX_LINK_CAP2 10'h06C
`define HSS_IDX_LINK_CTRL2 10'h070
`define HSS_IDX_LINK_STAT2 10'h072
`define HSS_IDX_SLOT_CAP2 10'h074
`define HSS_IDX_IRQ_MASK 10'h080

// slot status fields
`define HSS_ST_BUTTON 0
`define HSS_ST_PFAULT 1
`define HSS_ST_LATCH_CHG 2
`define HSS_ST_PRES_CHG 3
`define HSS_ST_CMD_DONE 4
`define HSS_ST_LATCH 5
`define HSS_ST_PRESENCE 6
`define HSS_ST_INTERLOCK 7
`define HSS_ST_LINK_CHG 8
`define HSS_ST_W1C_MASK 16'h011F

// slot control fields
`define HSS_CT_HP_IRQ_EN 5
`define HSS_CT_ATTN_LO 6
`define HSS_CT_PIND_LO 8
`define HSS_CT_POWER_OFF 10
`define HSS_CT_INTERLOCK 11
`define HSS_CT_LINK_EN 12
`define HSS_CT_EN_MASK 16'h101F
`define HSS_CT_RW_MASK 16'h17FF

// reset values
`define HSS_RST_SLOT_CTRL 16'h01C0
`define HSS_RST_IRQ_MASK 16'h011F

`endif

/* logic/hss_pkg.sv */
package hss_pkg;

	typedef struct packed {
		logic button;
		logic power_fault;
		logic latch_open;
		logic presence;
		logic interlock;
	} hss_pins_s;

	typedef struct packed {
		logic [1:0] attn_ind;
		logic [1:0] power_ind;
		logic power_off;
		logic interlock_toggle;
	} hss_cmd_s;

	typedef enum logic [1:0] {
		HSS_IDLE = 2'b01,
		HSS_BUSY = 2'b10
	} hss_cmd_state_e;

endpackage

/* logic/hss_slot_status.sv */
`timescale 1ns/1ps
`include "hss_defines.svh"

module hss_sync3 #(
	parameter logic RST = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			q <= RST;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// a change counts only once two late stages agree
			if (s2_q == s3_q) begin
				q <= s3_q;
			end
		end
	end
endmodule

// one sticky event flag, cleared by writing one
module hss_w1c_bit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set,
	input wire logic clr,
	output logic flag_q
);
	// set wins, so an event that lands with the clear is not lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end
endmodule

// Notes on behaviour
// - an attention button press sets bit 0, held until software writes one to it.
// - a power fault from the slot power controller sets bit 1 until a one is written there.
// - any change of the retention latch sensor sets bit 2, cleared by writing one.
// - any change of card presence sets bit 3, cleared by writing one.
// - finishing an issued command sets bit 4, which stays set if set and clears on a one.
// - each single write to slot control counts as exactly one command.
// - bit 4 waits until all actions of the command, expander transfers included, end.
// - bit 5 shows the latch sensor live, zero closed and one open, reset zero.
// - bit 6 shows card presence live, zero empty and one present, reset one.
// - bit 7 shows the interlock state, zero disengaged and one engaged.
// - a toggle of the link active indication sets bit 8, cleared by writing one.
// - a set flag in bits 0 to 4 interrupts only if its slot control enable and the global enable are set; bit 8 never interrupts.
// - slot control bit 3 enables interrupts for presence change events.
module hss_slot_status (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire hss_pkg::hss_pins_s slot_pins,
	input wire logic link_active,
	output hss_pkg::hss_cmd_s exp_cmd,
	output logic exp_req,
	input wire logic exp_done,
	output logic irq
);
	import hss_pkg::*;

	hss_pins_s pins_s;
	hss_pins_s pins_last_q;
	logic link_last_q;
	logic [15:0] status_flags;
	logic button_flag_q;
	logic pfault_flag_q;
	logic latch_chg_flag_q;
	logic pres_chg_flag_q;
	logic cmd_done_flag_q;
	logic link_chg_flag_q;
	logic status_wr;
	logic [15:0] ctrl_q;
	logic [15:0] mask_q;
	logic [15:0] events;
	logic [15:0] live;
	logic [15:0] status_rd;
	hss_cmd_state_e state_q;
	logic [9:0] idx;
	logic setup;
	logic access;
	logic hit_ctrl;
	logic hit_status;
	logic hit_mask;
	logic hit_rsvd;
	logic mapped;
	logic wr_done;
	logic cmd_issue;
	logic [31:0] rd_d;

	hss_sync3 #(.RST(1'b0)) u_sync_button (
		.pclk(pclk),
		.presetn(presetn),
		.d(slot_pins.button),
		.q(pins_s.button)
	);

	hss_sync3 #(.RST(1'b0)) u_sync_pfault (
		.pclk(pclk),
		.presetn(presetn),
		.d(slot_pins.power_fault),
		.q(pins_s.power_fault)
	);

	hss_sync3 #(.RST(1'b0)) u_sync_latch (
		.pclk(pclk),
		.presetn(presetn),
		.d(slot_pins.latch_open),
		.q(pins_s.latch_open)
	);

	// presence resets to one so a seated card gives no false change
	hss_sync3 #(.RST(1'b1)) u_sync_presence (
		.pclk(pclk),
		.presetn(presetn),
		.d(slot_pins.presence),
		.q(pins_s.presence)
	);

	hss_sync3 #(.RST(1'b0)) u_sync_interlock (
		.pclk(pclk),
		.presetn(presetn),
		.d(slot_pins.interlock),
		.q(pins_s.interlock)
	);

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign access = psel && penable;

	always_comb begin
		hit_ctrl = 1'b0;
		hit_status = 1'b0;
		hit_mask = 1'b0;
		hit_rsvd = 1'b0;
		if (idx == `HSS_IDX_SLOT_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (idx == `HSS_IDX_SLOT_STATUS) begin
			hit_status = 1'b1;
		end else if (idx == `HSS_IDX_IRQ_MASK) begin
			hit_mask = 1'b1;
		end else if (idx == `HSS_IDX_DEV_CAP2 || idx == `HSS_IDX_DEV_CTRL2 ||
			idx == `HSS_IDX_DEV_STAT2 || idx == `HSS_IDX_LINK_CAP2 ||
			idx == `HSS_IDX_LINK_CTRL2 || idx == `HSS_IDX_LINK_STAT2 ||
			idx == `HSS_IDX_SLOT_CAP2) begin
			hit_rsvd = 1'b1;
		end
	end

	assign mapped = hit_ctrl || hit_status || hit_mask || hit_rsvd;

	// a slot control write stalls while the previous command is still out
	assign pready = !(access && pwrite && hit_ctrl && state_q != HSS_IDLE);
	assign pslverr = access && !mapped;
	assign wr_done = access && pready && pwrite && mapped;

	assign cmd_issue = wr_done && hit_ctrl;

	always_comb begin
		events = 16'h0000;
		events[`HSS_ST_BUTTON] = pins_s.button && !pins_last_q.button;
		events[`HSS_ST_PFAULT] = pins_s.power_fault && !pins_last_q.power_fault;
		events[`HSS_ST_LATCH_CHG] = pins_s.latch_open != pins_last_q.latch_open;
		events[`HSS_ST_PRES_CHG] = pins_s.presence != pins_last_q.presence;
		events[`HSS_ST_CMD_DONE] = state_q == HSS_BUSY && exp_done;
		events[`HSS_ST_LINK_CHG] = link_active != link_last_q;
	end

	always_comb begin
		live = 16'h0000;
		live[`HSS_ST_LATCH] = pins_s.latch_open;
		live[`HSS_ST_PRESENCE] = pins_s.presence;
		live[`HSS_ST_INTERLOCK] = pins_s.interlock;
	end

	assign status_rd = (status_flags & `HSS_ST_W1C_MASK) | live;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_last_q <= '0;
			pins_last_q.presence <= 1'b1;
			link_last_q <= 1'b0;
		end else begin
			pins_last_q <= pins_s;
			link_last_q <= link_active;
		end
	end

	assign status_wr = wr_done && hit_status;

	hss_w1c_bit u_flag_button (
		.pclk(pclk),
		.presetn(presetn),
		.set(events[`HSS_ST_BUTTON]),
		.clr(status_wr && pwdata[`HSS_ST_BUTTON]),
		.flag_q(button_flag_q)
	);

	hss_w1c_bit u_flag_pfault (
		.pclk(pclk),
		.presetn(presetn),
		.set(events[`HSS_ST_PFAULT]),
		.clr(status_wr && pwdata[`HSS_ST_PFAULT]),
		.flag_q(pfault_flag_q)
	);

	hss_w1c_bit u_flag_latch_chg (
		.pclk(pclk),
		.presetn(presetn),
		.set(events[`HSS_ST_LATCH_CHG]),
		.clr(status_wr && pwdata[`HSS_ST_LATCH_CHG]),
		.flag_q(latch_chg_flag_q)
	);

	hss_w1c_bit u_flag_pres_chg (
		.pclk(pclk),
		.presetn(presetn),
		.set(events[`HSS_ST_PRES_CHG]),
		.clr(status_wr && pwdata[`HSS_ST_PRES_CHG]),
		.flag_q(pres_chg_flag_q)
	);

	hss_w1c_bit u_flag_cmd_done (
		.pclk(pclk),
		.presetn(presetn),
		.set(events[`HSS_ST_CMD_DONE]),
		.clr(status_wr && pwdata[`HSS_ST_CMD_DONE]),
		.flag_q(cmd_done_flag_q)
	);

	hss_w1c_bit u_flag_link_chg (
		.pclk(pclk),
		.presetn(presetn),
		.set(events[`HSS_ST_LINK_CHG]),
		.clr(status_wr && pwdata[`HSS_ST_LINK_CHG]),
		.flag_q(link_chg_flag_q)
	);

	// unused positions stay zero
	always_comb begin
		status_flags = 16'h0000;
		status_flags[`HSS_ST_BUTTON] = button_flag_q;
		status_flags[`HSS_ST_PFAULT] = pfault_flag_q;
		status_flags[`HSS_ST_LATCH_CHG] = latch_chg_flag_q;
		status_flags[`HSS_ST_PRES_CHG] = pres_chg_flag_q;
		status_flags[`HSS_ST_CMD_DONE] = cmd_done_flag_q;
		status_flags[`HSS_ST_LINK_CHG] = link_chg_flag_q;
	end

	// interlock control always reads back zero, it is a toggle strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `HSS_RST_SLOT_CTRL;
		end else if (cmd_issue) begin
			ctrl_q <= pwdata[15:0] & `HSS_CT_RW_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= `HSS_RST_IRQ_MASK;
		end else if (wr_done && hit_mask) begin
			mask_q <= pwdata[15:0] & `HSS_ST_W1C_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= HSS_IDLE;
			exp_req <= 1'b0;
			exp_cmd <= '0;
		end else begin
			case (state_q)
				HSS_IDLE: begin
					if (cmd_issue) begin
						state_q <= HSS_BUSY;
						exp_req <= 1'b1;
						exp_cmd.attn_ind <= pwdata[`HSS_CT_ATTN_LO+1:`HSS_CT_ATTN_LO];
						exp_cmd.power_ind <= pwdata[`HSS_CT_PIND_LO+1:`HSS_CT_PIND_LO];
						exp_cmd.power_off <= pwdata[`HSS_CT_POWER_OFF];
						exp_cmd.interlock_toggle <= pwdata[`HSS_CT_INTERLOCK];
					end
				end
				HSS_BUSY: begin
					if (exp_done) begin
						state_q <= HSS_IDLE;
						exp_req <= 1'b0;
					end
				end
				default: begin
					state_q <= HSS_IDLE;
					exp_req <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= ctrl_q[`HSS_CT_HP_IRQ_EN] &&
				|(status_flags & mask_q & {3'b000, ctrl_q[`HSS_CT_LINK_EN], 7'b0000000,
				ctrl_q[4:0]});
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_d = {16'h0000, ctrl_q & ~(16'h0001 << `HSS_CT_INTERLOCK)};
		end else if (hit_status) begin
			rd_d = {16'h0000, status_rd};
		end else if (hit_mask) begin
			rd_d = {16'h0000, mask_q};
		end
	end

	// read data captured in setup so it is a flop during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_d;
		end
	end

endmodule

/* tb/hss_exp_model.sv */
`timescale 1ns/1ps
module hss_exp_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic exp_req,
	input wire logic [3:0] dly,
	output logic exp_done
);
	logic [3:0] cnt_q;
	// done only after all transfers
	// one pulse per command: the request is still high in the same cycle as done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
			exp_done <= 1'b0;
		end else begin
			exp_done <= exp_req && !exp_done && cnt_q == dly;
			if (!exp_req || exp_done || cnt_q == dly) begin
				cnt_q <= 4'h0;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule

/* tb/hss_slot_status_properties.sv */
`timescale 1ns/1ps
module hss_slot_status_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire hss_pkg::hss_cmd_s exp_cmd,
	input wire logic exp_req,
	input wire logic exp_done
);
	import hss_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic rd_setup;
	assign acc = psel && penable;
	assign rd_setup = psel && !penable && !pwrite;
	chk_wait_done: assert property (exp_req && !exp_done |=> exp_req)
		else $error("request dropped early");
	chk_done_ends: assert property (exp_req && exp_done |=> !exp_req)
		else $error("request stuck");
	chk_busy_stall: assert property (acc && pwrite && paddr == 12'h160 && exp_req && !exp_done |-> !pready)
		else $error("second command not stalled");
	chk_cmd_issue: assert property (acc && pready && pwrite && paddr == 12'h160 |=> exp_req)
		else $error("write issued no command");
	chk_cmd_stable: assert property (exp_req && $past(exp_req) |-> $stable(exp_cmd))
		else $error("command changed in flight");
	chk_rsvd_ok: assert property (acc && paddr == 12'h190 |-> pready && !pslverr)
		else $error("reserved access refused");
	chk_rsvd_zero: assert property (rd_setup && paddr >= 12'h190 && paddr <= 12'h1D0 |=> prdata == 32'h0)
		else $error("reserved read not zero");
	chk_upper_zero: assert property (rd_setup |=> prdata[31:16] == 16'h0)
		else $error("upper half not zero");
endmodule
bind hss_slot_status hss_slot_status_chk i_hss_slot_status_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .exp_cmd(exp_cmd), .exp_req(exp_req), .exp_done(exp_done));

/* tb/test_hss_slot_status.sv */
`timescale 1ns/1ps
module test_hss_slot_status;
	import hss_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link, exp_req, exp_done, irq, req_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	hss_pins_s pins;
	hss_cmd_s cmd;
	logic [3:0] dly;
	logic [7:0] rnd;
	logic [31:0] exp_q[$];
	logic [11:0] rsv[7] = '{12'h190, 12'h1A0, 12'h1A8, 12'h1B0, 12'h1C0, 12'h1C8, 12'h1D0};
	int bad_count, samples_checked, ncmd;
	hss_slot_status i_hss_slot_status (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slot_pins(pins), .link_active(link),
		.exp_cmd(cmd), .exp_req(exp_req), .exp_done(exp_done), .irq(irq));
	hss_exp_model i_hss_exp_model (.pclk(pclk), .presetn(presetn), .exp_req(exp_req),
		.dly(dly), .exp_done(exp_done));
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task cmp(input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (got !== want) begin
			bad_count++;
			$display("mismatch %0t got %h want %h", $time, got, want);
		end
	endtask
	task report_and_stop;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (3000) @(posedge pclk);
		bad_count++;
		report_and_stop();
	end
	always @(posedge pclk) begin
		req_q <= exp_req;
		if (exp_req === 1'b1 && req_q === 1'b0) ncmd++;
		if (psel && penable && pready && !pwrite) cmp(prdata, exp_q.pop_front());
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, link, dly} = '0;
		pins = 5'h02;
		rnd = 8'h13;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h168, 32'h40);
		foreach (rsv[i]) begin
			apb(1'b1, rsv[i], 32'hFFFFFFFF);
			rd(rsv[i], 32'h0);
		end
		rd(12'h004, 32'h0);
		pins <= 5'h1B;
		link <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(12'h168, 32'h1C3);
		apb(1'b1, 12'h168, 32'h5);
		rd(12'h168, 32'h1C2);
		apb(1'b1, 12'h168, 32'h11F);
		rd(12'h168, 32'hC0);
		cmp({31'h0, irq}, 32'h0);
		rnd = lfsr(rnd);
		dly <= 4'h6;
		// second write lands while the first command is still busy
		apb(1'b1, 12'h160, {22'h0, rnd[3:0], 6'h30});
		apb(1'b1, 12'h160, {22'h0, rnd[7:4], 6'h30});
		repeat (12) @(posedge pclk);
		rd(12'h168, 32'hD0);
		cmp(ncmd, 32'h2);
		cmp({31'h0, irq}, 32'h1);
		apb(1'b1, 12'h200, 32'h0);
		repeat (3) @(posedge pclk);
		cmp({31'h0, irq}, 32'h0);
		apb(1'b1, 12'h200, 32'h11F);
		apb(1'b1, 12'h168, 32'h10);
		dly <= 4'h0;
		apb(1'b1, 12'h160, 32'h28);
		repeat (4) @(posedge pclk);
		cmp({31'h0, irq}, 32'h0);
		// card pulled: only presence changes, so only its enable can raise irq
		pins <= 5'h19;
		repeat (8) @(posedge pclk);
		cmp({31'h0, irq}, 32'h1);
		rd(12'h168, 32'h98);
		report_and_stop();
	end
endmodule
